// *** rtl/icsa_cfg.svh ***
`ifndef ICSA_CFG_SVH
`define ICSA_CFG_SVH

// ------------------------------------------------------------
// host i/o port offsets
// ------------------------------------------------------------
`define ICSA_IO_CSR_DATA      5'h10
`define ICSA_IO_PTR_WORD      5'h12
`define ICSA_IO_PTR_DWORD     5'h14
`define ICSA_IO_BCR_WORD      5'h16
`define ICSA_IO_BCR_DWORD     5'h1C

// ------------------------------------------------------------
// configuration space offset of the power-management data byte
// ------------------------------------------------------------
`define ICSA_CFG_PM_DATA      8'h47

// ------------------------------------------------------------
// register numbers behind the data ports
// ------------------------------------------------------------
`define ICSA_CSR_STATUS       8'h00
`define ICSA_CSR_MASK         8'h03
`define ICSA_CSR_BUS_TMO      8'h64
`define ICSA_CSR_MISS_CNT     8'h70
`define ICSA_BCR_PM_FIRST     8'h25
`define ICSA_BCR_PM_LAST      8'h2C

// ------------------------------------------------------------
// status register field positions
// ------------------------------------------------------------
`define ICSA_ST_ERR           15
`define ICSA_ST_RES14         14
`define ICSA_ST_COL           13
`define ICSA_ST_MISS          12
`define ICSA_ST_TMO           11
`define ICSA_ST_RXDONE        10
`define ICSA_ST_GLOBAL_IRQ_ENABLE          6
`define ICSA_ST_STOP          2
`define ICSA_ST_STRT          1
`define ICSA_ST_INIT          0

// ------------------------------------------------------------
// mask register field positions
// ------------------------------------------------------------
`define ICSA_MK_MISS          12
`define ICSA_MK_TMO           11
`define ICSA_MK_RXDONE        10
`define ICSA_MK_LAPP          5

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ICSA_PTR_RST          8'h00
`define ICSA_MASK_RST         3'h0
`define ICSA_PM_RST           8'h00
`define ICSA_TMO_RST          16'h0600

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ICSA_SQE_BIT_TIMES    20
`define ICSA_CLK_PERIOD_NS    8
`define ICSA_TMO_UNIT_NS      100
`define ICSA_TMO_UNIT_CYC     ((`ICSA_TMO_UNIT_NS + `ICSA_CLK_PERIOD_NS - 1) / `ICSA_CLK_PERIOD_NS)

`endif

// *** rtl/icsa_pkg.sv ***
package icsa_pkg;

   // decoded target of a host i/o access
   typedef enum logic [1:0]
   {
      ICSA_SEL_NONE = 2'h0,
      ICSA_SEL_CSR  = 2'h1,
      ICSA_SEL_PTR  = 2'h3,
      ICSA_SEL_BCR  = 2'h2
   } icsa_sel_e;

   // collision-after-transmit watch
   typedef enum logic
   {
      ICSA_SQE_IDLE = 1'b0,
      ICSA_SQE_WAIT = 1'b1
   } icsa_sqe_e;

   typedef logic [7:0]  icsa_regnum_t;
   typedef logic [15:0] icsa_tmo_t;

endpackage : icsa_pkg

// *** rtl/icsa_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// events and settings shared between register bank and watchdogs
interface icsa_evt_if;
   logic              tx_end;
   logic              bit_tick;
   logic              bus_req;
   icsa_pkg::icsa_tmo_t tmo_limit;
   logic              sqe_fail;
   logic              bus_tmo;

   modport bank (output tx_end, output bit_tick, output bus_req, output tmo_limit,
                 input sqe_fail, input bus_tmo);
   modport evt  (input tx_end, input bit_tick, input bus_req, input tmo_limit,
                 output sqe_fail, output bus_tmo);
endinterface : icsa_evt_if

`default_nettype wire

// *** rtl/icsa_evt.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "icsa_cfg.svh"

module icsa_evt
(
   input  wire logic  mclk,
   input  wire logic  reset,
   input  wire logic  col_pin,
   input  wire logic  gnt_n_pin,
   icsa_evt_if.evt    e
);
   import icsa_pkg::*;

   localparam int SQE_N = `ICSA_SQE_BIT_TIMES;
   localparam int UNIT  = `ICSA_TMO_UNIT_CYC;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] pin_in;
   logic [1:0] s1_r, s2_r, s3_r, stb_r;
   logic [1:0] stb_nxt;
   assign pin_in = {gnt_n_pin, col_pin};

   // a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_sync
         always_comb
         begin
            stb_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stb_r[i];
         end
         always_ff @(posedge mclk or posedge reset)
         begin
            if (reset)
            begin
               s1_r[i]  <= 1'b0;
               s2_r[i]  <= 1'b0;
               s3_r[i]  <= 1'b0;
               stb_r[i] <= 1'b0;
            end
            else
            begin
               s1_r[i]  <= pin_in[i];
               s2_r[i]  <= s1_r[i];
               s3_r[i]  <= s2_r[i];
               stb_r[i] <= stb_nxt[i];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // collision check after transmit, and bus grant watchdog
   // ------------------------------------------------------------
   icsa_sqe_e sqe_r, sqe_nxt;
   logic [4:0]  bit_r, bit_nxt;
   logic [3:0]  pre_r, pre_nxt;
   icsa_tmo_t   unit_r, unit_nxt;
   logic        fired_r, fired_nxt;
   logic        sqe_fail_nxt, tmo_nxt, sqe_fail_r, tmo_r;

   always_comb
   begin
      sqe_nxt      = sqe_r;
      bit_nxt      = bit_r;
      sqe_fail_nxt = 1'b0;
      unique case (sqe_r)
         ICSA_SQE_IDLE:
         begin
            bit_nxt = 5'h00;
            if (e.tx_end)
               sqe_nxt = ICSA_SQE_WAIT;
         end
         ICSA_SQE_WAIT:
         begin
            if (stb_r[0])
               sqe_nxt = ICSA_SQE_IDLE;
            else if (e.bit_tick)
            begin
               if (bit_r == 5'(SQE_N - 1))
               begin
                  sqe_fail_nxt = 1'b1;
                  sqe_nxt      = ICSA_SQE_IDLE;
               end
               else
                  bit_nxt = bit_r + 5'h01;
            end
         end
      endcase
      // request pending while grant (active low) stays high
      pre_nxt   = 4'h0;
      unit_nxt  = 16'h0000;
      fired_nxt = 1'b0;
      tmo_nxt   = 1'b0;
      if (e.bus_req && stb_r[1])
      begin
         fired_nxt = fired_r;
         unit_nxt  = unit_r;
         pre_nxt   = (pre_r == 4'(UNIT - 1)) ? 4'h0 : pre_r + 4'h1;
         if (pre_r == 4'(UNIT - 1) && unit_r != 16'hFFFF)
            unit_nxt = unit_r + 16'h0001;
         if (!fired_r && e.tmo_limit != 16'h0000 && unit_r >= e.tmo_limit)
         begin
            tmo_nxt   = 1'b1;
            fired_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sqe_r      <= ICSA_SQE_IDLE;
         bit_r      <= 5'h00;
         pre_r      <= 4'h0;
         unit_r     <= 16'h0000;
         fired_r    <= 1'b0;
         sqe_fail_r <= 1'b0;
         tmo_r      <= 1'b0;
      end
      else
      begin
         sqe_r      <= sqe_nxt;
         bit_r      <= bit_nxt;
         pre_r      <= pre_nxt;
         unit_r     <= unit_nxt;
         fired_r    <= fired_nxt;
         sqe_fail_r <= sqe_fail_nxt;
         tmo_r      <= tmo_nxt;
      end
   end

   assign e.sqe_fail = sqe_fail_r;
   assign e.bus_tmo  = tmo_r;

endmodule : icsa_evt

`default_nettype wire

// *** rtl/icsa_top.sv ***
// Summary of operation
// - read-only pm data byte at config 47h
// - pm byte aliased onto bus config 37-44
// - pointer port at 12h word, 14h dword
// - status data port 10h uses pointer
// - bus config port 16h/1Ch uses pointer
// - pointer bits 7-0 held, rest zero
// - pointer cleared by resets, stop ignored
// - interrupt flags clear on writing one
// - bit 15 is live OR of errors
// - bit 14 always reads zero
// - collision missing 20 bits after transmit
// - collision error suppressed per duplex/port mode
// - collision error sets summary, never interrupts
// - missed frame sets flag, bumps counter
// - missed frame interrupts when enabled, unmasked
// - ungranted bus request past timeout flags
// - bus timeout interrupts when enabled, unmasked
// - receive done on last, or first with look-ahead set
// - receive done interrupts when enabled, unmasked
// - error flags clear: one, reset, stop
// - receive flag clears: one, reset, stop
// - interrupt only with enable and unmasked flag
`timescale 1ns/1ps
`default_nettype none
`include "icsa_cfg.svh"

module icsa_top
#(
   parameter int MFC_W = 16
)
(
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire logic                 sw_reset,
   input  wire logic                 dword_mode,
   input  wire logic                 io_rd,
   input  wire logic                 io_wr,
   input  wire logic [4:0]           io_addr,
   input  wire logic [31:0]          io_wdata,
   output logic [31:0]               io_rdata,
   output logic                      io_rvalid,
   input  wire logic                 cfg_rd,
   input  wire logic [7:0]           cfg_addr,
   output logic [7:0]                cfg_rdata,
   input  wire logic                 ee_load,
   input  wire logic [7:0]           ee_byte,
   input  wire logic                 tx_end,
   input  wire logic                 net_bit_tick,
   input  wire logic                 col_pin,
   input  wire logic                 full_duplex,
   input  wire logic                 mii_sel,
   input  wire logic                 phy_half_duplex,
   input  wire logic                 phy_10mbps,
   input  wire logic                 bus_req,
   input  wire logic                 gnt_n_pin,
   input  wire logic                 frame_missed,
   input  wire logic                 rx_last_desc_done,
   input  wire logic                 rx_first_desc_done,
   output logic                      irq_n,
   output logic                      stop_out,
   output logic                      look_ahead_enable
);
   import icsa_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (MFC_W < 1 || MFC_W > 32)
   begin : g_bad_width
      $error("icsa_top: MFC_W must be 1 to 32");
   end

   // ------------------------------------------------------------
   // watchdogs for collision check and bus grant
   // ------------------------------------------------------------
   icsa_evt_if ev ();
   icsa_tmo_t  tmo_r, tmo_nxt;

   assign ev.tx_end    = tx_end;
   assign ev.bit_tick  = net_bit_tick;
   assign ev.bus_req   = bus_req;
   assign ev.tmo_limit = tmo_r;

   icsa_evt u_evt
   (
      .mclk      (mclk),
      .reset     (reset),
      .col_pin   (col_pin),
      .gnt_n_pin (gnt_n_pin),
      .e         (ev)
   );

   // ------------------------------------------------------------
   // host access decode
   // ------------------------------------------------------------
   icsa_sel_e sel;

   // pointer and bus config port offsets shift with the i/o mode; status data port stays at 10h
   always_comb
   begin
      sel = ICSA_SEL_NONE;
      if (io_addr == `ICSA_IO_CSR_DATA)
         sel = ICSA_SEL_CSR;
      else if (io_addr == (dword_mode ? `ICSA_IO_PTR_DWORD : `ICSA_IO_PTR_WORD))
         sel = ICSA_SEL_PTR;
      else if (io_addr == (dword_mode ? `ICSA_IO_BCR_DWORD : `ICSA_IO_BCR_WORD))
         sel = ICSA_SEL_BCR;
   end

   logic wr_ptr, wr_csr, wr_bcr;
   assign wr_ptr = io_wr && sel == ICSA_SEL_PTR;
   assign wr_csr = io_wr && sel == ICSA_SEL_CSR;
   assign wr_bcr = io_wr && sel == ICSA_SEL_BCR;

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   icsa_regnum_t     ptr_r, ptr_nxt;
   logic [7:0]       pm_r, pm_nxt;
   logic             col_r, col_nxt;
   logic             miss_r, miss_nxt;
   logic             tmof_r, tmof_nxt;
   logic             rxd_r, rxd_nxt;
   logic             global_irq_enable_r, global_irq_enable_nxt;
   logic             stop_r, stop_nxt;
   logic [2:0]       mask_r, mask_nxt;
   logic             lapp_r, lapp_nxt;
   logic [MFC_W-1:0] mfc_r, mfc_nxt;
   logic [31:0]      rdata_r, rdata_nxt;
   logic             rvalid_r;
   logic [7:0]       cfg_r, cfg_nxt;

   logic in_controller_status_control, in_interrupt_mask_register, stop_set, flag_clr, col_ok, bcr_pm;
   logic err;
   logic [31:0] controller_status_control_val;

   assign in_controller_status_control  = wr_csr && ptr_r == `ICSA_CSR_STATUS;
   assign in_interrupt_mask_register  = wr_csr && ptr_r == `ICSA_CSR_MASK;
   assign stop_set = in_controller_status_control && io_wdata[`ICSA_ST_STOP];
   assign flag_clr = sw_reset || stop_set;
   assign bcr_pm   = ptr_r >= `ICSA_BCR_PM_FIRST && ptr_r <= `ICSA_BCR_PM_LAST;

   // collision result only counts in half duplex and, on mii, 10 mb/s
   assign col_ok = !full_duplex && (!mii_sel || (phy_half_duplex && phy_10mbps));

   // error summary is live, never stored
   assign err = col_r | miss_r | tmof_r;

   // status word as seen by the host
   always_comb
   begin
      controller_status_control_val                 = 32'h0000_0000;
      controller_status_control_val[`ICSA_ST_ERR]   = err;
      controller_status_control_val[`ICSA_ST_RES14] = 1'b0;
      controller_status_control_val[`ICSA_ST_COL]   = col_r;
      controller_status_control_val[`ICSA_ST_MISS]  = miss_r;
      controller_status_control_val[`ICSA_ST_TMO]   = tmof_r;
      controller_status_control_val[`ICSA_ST_RXDONE] = rxd_r;
      controller_status_control_val[`ICSA_ST_GLOBAL_IRQ_ENABLE]  = global_irq_enable_r;
      controller_status_control_val[`ICSA_ST_STOP]  = stop_r;
   end

   // ------------------------------------------------------------
   // next-state computation
   // ------------------------------------------------------------
   always_comb
   begin
      // pointer keeps only its low byte; stop leaves it alone
      ptr_nxt = ptr_r;
      if (sw_reset)
         ptr_nxt = `ICSA_PTR_RST;
      else if (wr_ptr)
         ptr_nxt = io_wdata[7:0];

      // pm byte from serial memory, or test writes through the alias
      pm_nxt = pm_r;
      if (ee_load)
         pm_nxt = ee_byte;
      else if (wr_bcr && bcr_pm)
         pm_nxt = io_wdata[7:0];

      // sticky flags: hardware set beats host write-one clear
      col_nxt  = (col_r  && !(in_controller_status_control && io_wdata[`ICSA_ST_COL]))
                 || (ev.sqe_fail && col_ok);
      miss_nxt = (miss_r && !(in_controller_status_control && io_wdata[`ICSA_ST_MISS]))
                 || frame_missed;
      tmof_nxt = (tmof_r && !(in_controller_status_control && io_wdata[`ICSA_ST_TMO]))
                 || ev.bus_tmo;
      rxd_nxt  = (rxd_r  && !(in_controller_status_control && io_wdata[`ICSA_ST_RXDONE]))
                 || rx_last_desc_done
                 || (rx_first_desc_done && lapp_r);
      if (flag_clr)
      begin
         col_nxt  = 1'b0;
         miss_nxt = 1'b0;
         tmof_nxt = 1'b0;
         rxd_nxt  = 1'b0;
      end

      // interrupt enable and stop control
      global_irq_enable_nxt = in_controller_status_control ? io_wdata[`ICSA_ST_GLOBAL_IRQ_ENABLE] : global_irq_enable_r;
      stop_nxt = stop_r;
      if (in_controller_status_control && (io_wdata[`ICSA_ST_STRT] || io_wdata[`ICSA_ST_INIT]))
         stop_nxt = 1'b0;
      if (sw_reset || stop_set)
      begin
         stop_nxt = 1'b1;
         global_irq_enable_nxt = 1'b0;
      end

      // mask register
      mask_nxt = mask_r;
      lapp_nxt = lapp_r;
      if (in_interrupt_mask_register)
      begin
         mask_nxt = {io_wdata[`ICSA_MK_MISS], io_wdata[`ICSA_MK_TMO], io_wdata[`ICSA_MK_RXDONE]};
         lapp_nxt = io_wdata[`ICSA_MK_LAPP];
      end

      // bus timeout and missed-frame counter
      tmo_nxt = tmo_r;
      if (wr_csr && ptr_r == `ICSA_CSR_BUS_TMO)
         tmo_nxt = io_wdata[15:0];
      mfc_nxt = mfc_r;
      if (wr_csr && ptr_r == `ICSA_CSR_MISS_CNT)
         mfc_nxt = io_wdata[MFC_W-1:0];
      if (frame_missed)
         mfc_nxt = mfc_r + MFC_W'(1);

      // read data through the pointer
      rdata_nxt = rdata_r;
      if (io_rd)
      begin
         rdata_nxt = 32'h0000_0000;
         unique case (sel)
            ICSA_SEL_PTR:
               rdata_nxt = {24'h00_0000, ptr_r};
            ICSA_SEL_CSR:
            begin
               if (ptr_r == `ICSA_CSR_STATUS)
                  rdata_nxt = controller_status_control_val;
               else if (ptr_r == `ICSA_CSR_MASK)
               begin
                  rdata_nxt[`ICSA_MK_MISS]   = mask_r[2];
                  rdata_nxt[`ICSA_MK_TMO]    = mask_r[1];
                  rdata_nxt[`ICSA_MK_RXDONE] = mask_r[0];
                  rdata_nxt[`ICSA_MK_LAPP]   = lapp_r;
               end
               else if (ptr_r == `ICSA_CSR_BUS_TMO)
                  rdata_nxt = {16'h0000, tmo_r};
               else if (ptr_r == `ICSA_CSR_MISS_CNT)
                  rdata_nxt[MFC_W-1:0] = mfc_r;
            end
            ICSA_SEL_BCR:
            begin
               if (bcr_pm)
                  rdata_nxt = {24'h00_0000, pm_r};
            end
            ICSA_SEL_NONE:
               rdata_nxt = 32'h0000_0000;
         endcase
      end

      // configuration space read
      cfg_nxt = cfg_r;
      if (cfg_rd)
         cfg_nxt = (cfg_addr == `ICSA_CFG_PM_DATA) ? pm_r : 8'h00;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ptr_r    <= `ICSA_PTR_RST;
         pm_r     <= `ICSA_PM_RST;
         col_r    <= 1'b0;
         miss_r   <= 1'b0;
         tmof_r   <= 1'b0;
         rxd_r    <= 1'b0;
         global_irq_enable_r   <= 1'b0;
         stop_r   <= 1'b1;
         mask_r   <= `ICSA_MASK_RST;
         lapp_r   <= 1'b0;
         tmo_r    <= `ICSA_TMO_RST;
         mfc_r    <= '0;
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
         cfg_r    <= 8'h00;
      end
      else
      begin
         ptr_r    <= ptr_nxt;
         pm_r     <= pm_nxt;
         col_r    <= col_nxt;
         miss_r   <= miss_nxt;
         tmof_r   <= tmof_nxt;
         rxd_r    <= rxd_nxt;
         global_irq_enable_r   <= global_irq_enable_nxt;
         stop_r   <= stop_nxt;
         mask_r   <= mask_nxt;
         lapp_r   <= lapp_nxt;
         tmo_r    <= tmo_nxt;
         mfc_r    <= mfc_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= io_rd;
         cfg_r    <= cfg_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // collision flag has no path to the interrupt
   assign irq_n = !(global_irq_enable_r && ((miss_r && !mask_r[2])
                             || (tmof_r && !mask_r[1])
                             || (rxd_r && !mask_r[0])));
   assign io_rdata          = rdata_r;
   assign io_rvalid         = rvalid_r;
   assign cfg_rdata         = cfg_r;
   assign stop_out          = stop_r;
   assign look_ahead_enable = lapp_r;

endmodule : icsa_top

`default_nettype wire

// *** verif/icsa_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// host port checker
// ------------------------------
module icsa_top_props
#(
   parameter int MFC_W = 16
)
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        sw_reset,
   input wire logic        io_rd,
   input wire logic        io_wr,
   input wire logic [31:0] io_rdata,
   input wire logic        io_rvalid,
   input wire logic        cfg_rd,
   input wire logic [7:0]  cfg_addr,
   input wire logic [7:0]  cfg_rdata,
   input wire logic        ee_load,
   input wire logic [7:0]  ee_byte,
   input wire logic        irq_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // read answer, pm byte load then read
   sequence s_answer;
      ##1 io_rvalid;
   endsequence
   sequence s_pm_read;
      $past(ee_load) && cfg_rd && cfg_addr == 8'h47;
   endsequence
   a_rd_answer: assert property (io_rd |-> s_answer)
      else $error("read strobe got no answer");
   a_rvalid_cause: assert property (io_rvalid |-> $past(io_rd))
      else $error("answer without read strobe");
   a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without read");
   a_cfg_other: assert property (cfg_rd && cfg_addr != 8'h47 |=> cfg_rdata == 8'h00)
      else $error("config read off pm byte not zero");
   a_pm_read: assert property (s_pm_read |=> cfg_rdata == $past(ee_byte, 2))
      else $error("pm byte not the loaded value");
   a_irq_sticky: assert property (!irq_n && !io_wr && !sw_reset |=> !irq_n)
      else $error("interrupt dropped without host action");
   a_irq_swrst: assert property (sw_reset |=> irq_n)
      else $error("interrupt active after software reset");
   a_reset_quiet: assert property ($fell(reset) |-> irq_n && !io_rvalid && io_rdata == 32'h0)
      else $error("outputs not idle after reset");
endmodule : icsa_top_props

bind icsa_top icsa_top_props #(.MFC_W(MFC_W)) icsa_top_props_inst (.mclk, .reset, .sw_reset, .io_rd, .io_wr,
   .io_rdata, .io_rvalid, .cfg_rd, .cfg_addr, .cfg_rdata, .ee_load, .ee_byte, .irq_n);
`default_nettype wire

// *** verif/icsa_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "icsa_cfg.svh"
// ------------------------------
// host software model
// ------------------------------
module icsa_host
(
   input  wire logic        mclk,
   output logic             dword_mode,
   output logic             io_rd,
   output logic             io_wr,
   output logic [4:0]       io_addr,
   output logic [31:0]      io_wdata,
   input  wire logic [31:0] io_rdata,
   input  wire logic        io_rvalid
);
   // idle bus at time zero
   initial
   begin
      {dword_mode, io_rd, io_wr, io_addr, io_wdata} = '0;
   end
   // one strobe, answer taken two edges on
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      io_rd    <= ~w;
      io_wr    <= w;
      io_addr  <= a;
      io_wdata <= d;
      @(posedge mclk);
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      @(posedge mclk);
      q = (io_rvalid === 1'b1) ? io_rdata : 'x;
   endtask : xfer
   // point first, defined numbers only, upper bits zero
   task automatic acc(input logic w, input logic bus_config_register, input logic [7:0] n, input logic [31:0] d,
                      output logic [31:0] q);
      xfer(1'b1, dword_mode ? `ICSA_IO_PTR_DWORD : `ICSA_IO_PTR_WORD, {24'h0, n}, q);
      xfer(w, !bus_config_register ? `ICSA_IO_CSR_DATA : dword_mode ? `ICSA_IO_BCR_DWORD : `ICSA_IO_BCR_WORD, d, q);
   endtask : acc
   task automatic mode(input logic b);
      @(posedge mclk);
      dword_mode <= b;
      @(posedge mclk);                             // new offsets settle before the next call picks them
   endtask : mode
endmodule : icsa_host
`default_nettype wire

// *** verif/icsa_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "icsa_cfg.svh"
// ------------------------------
// bench for the host port bank
// ------------------------------
module icsa_top_tb;
   logic        mclk, reset, dword_mode, io_rd, io_wr, io_rvalid, full_duplex, bus_req, gnt_n_pin, irq_n;
   logic [4:0]  io_addr;
   logic [31:0] io_wdata, io_rdata, q;
   logic [7:0]  cfg_addr, cfg_rdata, ee_byte;
   logic [6:0]  pv;
   logic        col_pin, rx_first, stop_out, look_ahead_enable;
   int          n_errors, samples_checked;

   icsa_top icsa_top_inst (.mclk, .reset, .sw_reset(pv[5]), .dword_mode, .io_rd, .io_wr, .io_addr, .io_wdata,
      .io_rdata, .io_rvalid, .cfg_rd(pv[0]), .cfg_addr, .cfg_rdata, .ee_load(pv[4]), .ee_byte, .tx_end(pv[3]),
      .net_bit_tick(pv[6]), .col_pin, .full_duplex, .mii_sel(1'b0), .phy_half_duplex(1'b0),
      .phy_10mbps(1'b0), .bus_req, .gnt_n_pin, .frame_missed(pv[2]), .rx_last_desc_done(pv[1]),
      .rx_first_desc_done(rx_first), .irq_n, .stop_out, .look_ahead_enable);
   icsa_host icsa_host_inst (.mclk, .dword_mode, .io_rd, .io_wr, .io_addr, .io_wdata, .io_rdata, .io_rvalid);

   // 8 ns clock
   always #4 mclk = ~mclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd(input logic bus_config_register, input logic [7:0] n, input logic [31:0] exp);
      icsa_host_inst.acc(1'b0, bus_config_register, n, 32'h0, q);
      chk(q, exp);
   endtask : rd
   task automatic wr(input logic [7:0] n, input logic [31:0] d);
      icsa_host_inst.acc(1'b1, 1'b0, n, d, q);
   endtask : wr
   // two event patterns on back-to-back edges
   task automatic pulse(input logic [6:0] m, input logic [6:0] n);
      @(posedge mclk);
      pv <= m;
      @(posedge mclk);
      pv <= n;
      @(posedge mclk);
      pv <= 7'h0;
   endtask : pulse
   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // hang guard
   initial
   begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      results();
   end

   // test sequence
   initial
   begin
      {mclk, pv, full_duplex, bus_req, col_pin, rx_first, n_errors, samples_checked} = '0;
      {reset, gnt_n_pin, cfg_addr, ee_byte} = {2'b11, 8'h46, 8'hA5};
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      icsa_host_inst.xfer(1'b0, `ICSA_IO_PTR_WORD, 32'h0, q);
      chk(q, 32'h0);
      pulse(7'h01, 7'h00);
      chk({24'h0, cfg_rdata}, 32'h0);
      cfg_addr <= `ICSA_CFG_PM_DATA;
      pulse(7'h10, 7'h01);
      @(posedge mclk);
      chk({24'h0, cfg_rdata}, 32'hA5);
      rd(1'b1, 8'h25, 32'hA5);
      $display("test pm byte done");
      pulse(7'h04, 7'h00);
      rd(1'b0, 8'h00, 32'h9004);
      wr(8'h00, 32'h4000);
      rd(1'b0, 8'h00, 32'h9004);
      wr(8'h00, 32'h0040);
      chk({31'h0, irq_n}, 32'h0);
      wr(8'h03, 32'h1000);
      chk({31'h0, irq_n}, 32'h1);
      rd(1'b0, 8'h70, 32'h1);
      wr(8'h00, 32'h1040);
      rd(1'b0, 8'h00, 32'h0044);
      $display("test missed frame done");
      wr(8'h64, 32'h1);
      bus_req   <= 1'b1;
      gnt_n_pin <= 1'b0;
      repeat (40) @(posedge mclk);
      rd(1'b0, 8'h00, 32'h0044);
      gnt_n_pin <= 1'b1;
      repeat (40) @(posedge mclk);
      bus_req <= 1'b0;
      rd(1'b0, 8'h00, 32'h8844);
      chk({31'h0, irq_n}, 32'h0);
      wr(8'h00, 32'h0840);
      chk({31'h0, irq_n}, 32'h1);
      $display("test bus timeout done");
      for (int i = 0; i < 3; i++)
      begin
         full_duplex <= i[0];
         col_pin     <= i[1];                      // third pass: collision answers in time
         pulse(7'h08, 7'h00);
         repeat (21) pulse(7'h40, 7'h00);
         repeat (8) @(posedge mclk);
         rd(1'b0, 8'h00, (i == 0) ? 32'hA044 : 32'h0044);
         chk({31'h0, irq_n}, 32'h1);
         wr(8'h00, 32'h2040);
      end
      $display("test collision done");
      pulse(7'h02, 7'h00);
      rd(1'b0, 8'h00, 32'h0444);
      chk({31'h0, irq_n}, 32'h0);
      wr(8'h00, 32'h0004);
      rd(1'b0, 8'h00, 32'h0004);
      wr(8'h03, 32'h0020);
      @(posedge mclk);
      rx_first <= 1'b1;
      @(posedge mclk);
      rx_first <= 1'b0;
      rd(1'b0, 8'h00, 32'h0404);
      chk({29'h0, irq_n, look_ahead_enable, stop_out}, 32'h7);
      $display("test look-ahead done");
      icsa_host_inst.mode(1'b1);
      rd(1'b1, 8'h2C, 32'hA5);
      icsa_host_inst.xfer(1'b1, `ICSA_IO_PTR_DWORD, 32'h0000FF03, q);
      icsa_host_inst.xfer(1'b0, `ICSA_IO_PTR_DWORD, 32'h0, q);
      chk({16'h0, q[15:0]}, 32'h3);
      pulse(7'h20, 7'h00);
      icsa_host_inst.xfer(1'b0, `ICSA_IO_PTR_DWORD, 32'h0, q);
      chk({16'h0, q[15:0]}, 32'h0);
      $display("test ports done");
      results();
   end
endmodule : icsa_top_tb
`default_nettype wire
